// ### inc/transient_stage_consts.svh
// constants of the intermittent transient earth-fault delay stage
`ifndef TRANSIENT_STAGE_CONSTS_SVH
`define TRANSIENT_STAGE_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ         250
`define TICK_US         1000
`define TICK_CYC        (`CLK_MHZ * `TICK_US)
`define SLOT_MS         16'd20
`define RELEASE_MS      16'd40
`define FORCE_MIN       5
`define FORCE_MS        (`FORCE_MIN * 60000)
`define PCT_FULL        16'd100

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_GRP1        8'h04
`define REG_GRP2        8'h08
`define REG_STATUS      8'h0c
`define REG_COUNTS      8'h10
`define REG_IRQ_STAT    8'h14
`define REG_IRQ_CLR     8'h18
`define REG_IRQ_EN      8'h1c
`define REG_REC_SEL     8'h20
`define REG_REC_TIME    8'h24
`define REG_REC_DATA    8'h28

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_FORCE      0
`define CTRL_FRC_START  1
`define CTRL_FRC_TRIP   2
`define CTRL_MAN_GRP    3
`define CTRL_SRC        6:4
`define CTRL_PEAK_SEL   7
`define CTRL_CLR_START  8
`define CTRL_CLR_TRIP   9

// ----------------------------------------
// setting group fields
// ----------------------------------------
`define GS_OP           7:0
`define GS_INTR         23:8
`define GS_U0           31:24
`define GRP_RST         32'h0000_0007

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_W           4
`define IRQ_START       0
`define IRQ_TRIP        1
`define IRQ_FORCE_TO    2
`define IRQ_BLOCK       3

// ----------------------------------------
// fault record
// ----------------------------------------
`define REC_DEPTH       8
`define REC_W           64

`endif

// ### inc/transient_stage_pkg.sv
// types of the intermittent transient earth-fault delay stage
`include "transient_stage_consts.svh"

package transient_stage_pkg;

    // gray along idle -> picked -> tripped; picked -> held flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PICK = 2'b01,
        ST_TRIP = 2'b11,
        ST_HELD = 2'b10
    } stage_state_t;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_DI   = 3'h1,
        SRC_VI   = 3'h2,
        SRC_LED  = 3'h3,
        SRC_VO   = 3'h4
    } grp_src_t;

    typedef struct packed {
        stage_state_t         st;
        logic [1:0]           di_sync;
        logic [17:0]          tick_cnt;
        logic [15:0]          slot_ms;
        logic [15:0]          gap_ms;
        logic [7:0]           dly_cnt;
        logic                 peak_ok;
        logic [7:0]           u0_max;
        logic                 forced;
        logic [18:0]          force_ms;
        logic                 frc_start;
        logic                 frc_trip;
        logic                 man_grp;
        grp_src_t             src;
        logic                 peak_sel;
        logic [31:0]          grp1;
        logic [31:0]          grp2;
        logic [15:0]          start_cnt;
        logic [15:0]          trip_cnt;
        logic [`IRQ_W-1:0]    irq_stat;
        logic [`IRQ_W-1:0]    irq_en;
        logic [2:0]           rec_sel;
        logic [31:0]          rdata;
        logic                 start;
        logic                 trip;
        logic                 blocked;
        logic                 grp;
    } stage_regs_t;

    typedef struct packed {
        logic [2:0]                           wptr;
        logic [`REC_DEPTH-1:0][`REC_W-1:0]    mem;
    } rec_regs_t;

endpackage

// ### rtl/fault_record_store.sv
// ring of the most recent detected faults
`timescale 1ns/10ps

module fault_record_store (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    // new record
    input  wire logic        i_wr,
    input  wire logic [31:0] i_time,
    input  wire logic [15:0] i_peak,
    input  wire logic [7:0]  i_u0,
    input  wire logic [6:0]  i_pct,
    input  wire logic        i_grp,
    // read back, age 0 is the newest
    input  wire logic [2:0]  i_sel,
    output logic      [31:0] o_time,
    output logic      [31:0] o_data
);
    import transient_stage_pkg::*;

    rec_regs_t   q;
    rec_regs_t   d;
    logic [2:0]  rd_idx;

    // ----------------------------------------
    // write side
    // ----------------------------------------
    always_comb begin
        d = q;
        if (i_wr) begin
            d.mem[q.wptr] = {i_time, i_grp, i_pct, i_u0, i_peak};
            d.wptr        = q.wptr + 3'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // read side
    // ----------------------------------------
    // oldest entries are overwritten silently once the ring is full
    assign rd_idx = q.wptr - 3'h1 - i_sel;
    assign o_time = q.mem[rd_idx][63:32];
    assign o_data = q.mem[rd_idx][31:0];

endmodule

// ### rtl/transient_earth_stage.sv
// delay and decision logic of the intermittent transient earth-fault stage
//
// Operation
// - outward fault: start, add one 20 ms slot
// - faults under 40 ms apart: trip at setting
// - gap over 40 ms: release, count restarts
// - fault within intermittent time keeps the count
// - gap over release plus intermittent clears count
// - trip only if peak exceeds fundamental peak
// - block input: show blocked, suppress start, trip
// - two setting groups, selectable by signal or hand
// - group source: none, input, virtual, indicator, output
// - shared force flag, self clears after five minutes
// - keep eight latest fault records
// - elapsed delay in percent, 100 means trip
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "transient_stage_consts.svh"

module transient_earth_stage #(
    parameter int P_TICK_CYCLES = `TICK_CYC,
    parameter int P_FORCE_MS    = `FORCE_MS
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    // direction detector and measurement
    input  wire logic        i_fault_det,
    input  wire logic [15:0] i_first_residual_peak_input,
    input  wire logic [15:0] i_second_residual_peak_input,
    input  wire logic [15:0] i_fund_peak,
    input  wire logic [7:0]  i_u0_level,
    input  wire logic [31:0] i_time_stamp,
    // blocking and group select sources
    input  wire logic        i_block,
    input  wire logic        i_grp_digital_pin,
    input  wire logic        i_grp_virtual_in,
    input  wire logic        i_grp_indicator,
    input  wire logic        i_grp_virtual_out,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // stage outputs
    output logic             o_start,
    output logic             o_trip,
    output logic             o_blocked,
    output logic             o_force_flag,
    output logic             o_active_group,
    output logic             o_irq
);
    import transient_stage_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic pick_group(input grp_src_t src, input logic man,
                                        input logic di, input logic vi,
                                        input logic led, input logic vo);
        logic g;
        g = man;
        unique case (src)
            SRC_NONE: g = man;
            SRC_DI:   g = di;
            SRC_VI:   g = vi;
            SRC_LED:  g = led;
            SRC_VO:   g = vo;
            default:  g = man;
        endcase
        return g;
    endfunction

    function automatic logic [6:0] pct_of(input logic [7:0] cnt, input logic [7:0] op);
        logic [15:0] p;
        p = `PCT_FULL;
        if (op != 8'h00) begin
            p = 16'({8'h00, cnt} * `PCT_FULL) / {8'h00, op};
        end
        if (p > `PCT_FULL) begin
            p = `PCT_FULL;
        end
        return p[6:0];
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    stage_regs_t  q;
    stage_regs_t  d;

    logic         tick;
    logic         grp;
    logic [31:0]  gs;
    logic [7:0]   op_slots;
    logic [15:0]  intr_ms;
    logic [15:0]  peak;
    logic         fault;
    logic         counted;
    logic [7:0]   cnt_after;
    logic [16:0]  clear_gap;
    logic [`IRQ_W-1:0] irq_ev;
    logic [`IRQ_W-1:0] irq_clr;
    logic         force_to;
    logic [31:0]  rec_time;
    logic [31:0]  rec_data;
    logic         wr_ctrl;

    assign tick      = (q.tick_cnt == 18'(P_TICK_CYCLES - 1));
    // the pin source is synchronised; the other sources are internal logic
    assign grp       = pick_group(q.src, q.man_grp, q.di_sync[1], i_grp_virtual_in,
                                  i_grp_indicator, i_grp_virtual_out);
    assign gs        = grp ? q.grp2 : q.grp1;
    assign op_slots  = gs[`GS_OP];
    assign intr_ms   = gs[`GS_INTR];
    assign peak      = q.peak_sel ? i_second_residual_peak_input
                                  : i_first_residual_peak_input;
    // faults under the residual voltage pickup are not counted
    assign fault     = i_fault_det && (i_u0_level >= gs[`GS_U0]) && !i_block;
    // one increment per 20 ms slot however many spikes land in it
    assign counted   = fault && (q.slot_ms == 16'h0000);
    assign cnt_after = (q.dly_cnt == 8'hff) ? q.dly_cnt : q.dly_cnt + 8'h01;
    assign clear_gap = {1'b0, `RELEASE_MS} + {1'b0, intr_ms};
    assign wr_ctrl   = i_wr && (i_addr == `REG_CTRL);
    assign irq_clr   = (i_wr && (i_addr == `REG_IRQ_CLR)) ? i_wdata[`IRQ_W-1:0] : '0;
    assign force_to  = q.forced && tick && (q.force_ms >= 19'(P_FORCE_MS - 1));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d         = q;
        irq_ev    = '0;
        d.di_sync = {q.di_sync[0], i_grp_digital_pin};
        d.grp     = grp;
        d.blocked = i_block;
        d.tick_cnt = tick ? 18'h0 : q.tick_cnt + 18'h1;

        if (tick) begin
            if (q.gap_ms != 16'hffff) begin
                d.gap_ms = q.gap_ms + 16'h1;
            end
            if (q.slot_ms != 16'h0000) begin
                d.slot_ms = q.slot_ms - 16'h1;
            end
        end

        // stage sequence
        unique case (q.st)
            ST_IDLE: begin
                if (fault) begin
                    d.st = ST_PICK;
                end
            end
            ST_PICK: begin
                // a fault in the release cycle keeps the stage up
                if ((q.gap_ms >= `RELEASE_MS) && !fault) begin
                    d.st = ST_HELD;
                end else if ((q.dly_cnt >= op_slots) && q.peak_ok) begin
                    d.st = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if ((q.gap_ms >= `RELEASE_MS) && !fault) begin
                    d.st      = ST_IDLE;
                    d.dly_cnt = 8'h00;
                    d.peak_ok = 1'b0;
                    d.u0_max  = 8'h00;
                end
            end
            ST_HELD: begin
                if (fault) begin
                    d.st = ST_PICK;
                end else if ({1'b0, q.gap_ms} > clear_gap) begin
                    d.st      = ST_IDLE;
                    d.dly_cnt = 8'h00;
                    d.peak_ok = 1'b0;
                    d.u0_max  = 8'h00;
                end
            end
        endcase

        // fault bookkeeping
        if (fault) begin
            d.gap_ms = 16'h0000;
            if (peak > i_fund_peak) begin
                d.peak_ok = 1'b1;
            end
            if (i_u0_level > q.u0_max) begin
                d.u0_max = i_u0_level;
            end
        end
        if (counted) begin
            d.dly_cnt = cnt_after;
            d.slot_ms = `SLOT_MS;
        end

        // blocking drops everything and holds the count at zero
        if (i_block) begin
            d.st      = ST_IDLE;
            d.dly_cnt = 8'h00;
            d.peak_ok = 1'b0;
            d.u0_max  = 8'h00;
            d.gap_ms  = 16'hffff;
        end

        // forcing flag and its timeout
        if (tick && q.forced) begin
            d.force_ms = q.force_ms + 19'h1;
        end
        if (force_to) begin
            d.forced   = 1'b0;
            d.force_ms = 19'h0;
            irq_ev[`IRQ_FORCE_TO] = 1'b1;
        end

        // outputs from the next state
        d.start = ((d.st == ST_PICK) || (d.st == ST_TRIP)
                   || (d.forced && d.frc_start)) && !i_block;
        d.trip  = ((d.st == ST_TRIP) || (d.forced && d.frc_trip))
                  && !i_block;

        // counters, the clear loses to a same-cycle edge
        if (wr_ctrl && i_wdata[`CTRL_CLR_START]) begin
            d.start_cnt = 16'h0000;
        end
        if (wr_ctrl && i_wdata[`CTRL_CLR_TRIP]) begin
            d.trip_cnt = 16'h0000;
        end
        if (d.start && !q.start) begin
            d.start_cnt = q.start_cnt + 16'h1;
            irq_ev[`IRQ_START] = 1'b1;
        end
        if (d.trip && !q.trip) begin
            d.trip_cnt = q.trip_cnt + 16'h1;
            irq_ev[`IRQ_TRIP] = 1'b1;
        end
        if (i_block && !q.blocked) begin
            irq_ev[`IRQ_BLOCK] = 1'b1;
        end

        // register writes
        if (i_wr) begin
            unique case (i_addr)
                `REG_CTRL: begin
                    // restarting force also restarts its timeout
                    if (i_wdata[`CTRL_FORCE] && !q.forced) begin
                        d.force_ms = 19'h0;
                    end
                    if (!force_to || !i_wdata[`CTRL_FORCE]) begin
                        d.forced = i_wdata[`CTRL_FORCE];
                    end
                    d.frc_start = i_wdata[`CTRL_FRC_START];
                    d.frc_trip  = i_wdata[`CTRL_FRC_TRIP];
                    d.man_grp   = i_wdata[`CTRL_MAN_GRP];
                    d.src       = grp_src_t'(i_wdata[`CTRL_SRC]);
                    d.peak_sel  = i_wdata[`CTRL_PEAK_SEL];
                end
                `REG_GRP1:    d.grp1    = i_wdata;
                `REG_GRP2:    d.grp2    = i_wdata;
                `REG_IRQ_EN:  d.irq_en  = i_wdata[`IRQ_W-1:0];
                `REG_REC_SEL: d.rec_sel = i_wdata[2:0];
                default: ;
            endcase
        end

        // sticky events, a set beats a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;

        // read data stands only in the cycle after the strobe
        d.rdata = 32'h0;
        if (i_rd) begin
            unique case (i_addr)
                `REG_CTRL:     d.rdata = {24'h0, q.peak_sel, q.src, q.man_grp,
                                          q.frc_trip, q.frc_start, q.forced};
                `REG_GRP1:     d.rdata = q.grp1;
                `REG_GRP2:     d.rdata = q.grp2;
                `REG_STATUS:   d.rdata = {9'h0, pct_of(q.dly_cnt, op_slots),
                                          q.dly_cnt, 3'h0, q.forced, q.grp,
                                          q.blocked, q.trip, q.start};
                `REG_COUNTS:   d.rdata = {q.trip_cnt, q.start_cnt};
                `REG_IRQ_STAT: d.rdata = {28'h0, q.irq_stat};
                `REG_IRQ_EN:   d.rdata = {28'h0, q.irq_en};
                `REG_REC_SEL:  d.rdata = {29'h0, q.rec_sel};
                `REG_REC_TIME: d.rdata = rec_time;
                `REG_REC_DATA: d.rdata = rec_data;
                default:       d.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q      <= '0;
            q.st   <= ST_IDLE;
            q.src  <= SRC_NONE;
            q.grp1 <= `GRP_RST;
            q.grp2 <= `GRP_RST;
            q.gap_ms <= 16'hffff;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // fault records
    // ----------------------------------------
    // a record is taken per counted slot, showing the delay reached with it
    fault_record_store u_records (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (counted),
        .i_time    (i_time_stamp),
        .i_peak    (peak),
        .i_u0      ((i_u0_level > q.u0_max) ? i_u0_level : q.u0_max),
        .i_pct     (pct_of(cnt_after, op_slots)),
        .i_grp     (grp),
        .i_sel     (q.rec_sel),
        .o_time    (rec_time),
        .o_data    (rec_data)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rdata        = q.rdata;
    assign o_start        = q.start;
    assign o_trip         = q.trip;
    assign o_blocked      = q.blocked;
    assign o_force_flag   = q.forced;
    assign o_active_group = q.grp;
    assign o_irq          = |(q.irq_stat & q.irq_en);

endmodule

// ### verification/fault_source_model.sv
// model of the sampled measurement and direction detector ahead of the stage
`timescale 1ns/10ps

module fault_source_model (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    // measurement towards the stage
    output logic             o_fault_det,
    output logic      [15:0] o_peak1,
    output logic      [15:0] o_peak2,
    output logic      [15:0] o_fund,
    output logic      [7:0]  o_u0,
    output logic      [31:0] o_time
);
    initial begin
        o_fault_det = 1'b0;
        o_peak1 = 16'h0;
        o_fund = 16'h0;
        o_u0 = 8'hff;
    end

    // unselected input never holds still, so a wrong select shows up
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_time <= 32'h0;
            o_peak2 <= 16'h5a5a;
        end else begin
            o_time <= o_time + 32'h1;
            o_peak2 <= ~o_peak2;
        end
    end

    // one outward fault: peaks stand as levels, detection is a one-cycle pulse
    task automatic fire(input logic [15:0] pk, input logic [15:0] fd);
        @(posedge i_sys_clk);
        o_fault_det <= 1'b1;
        o_peak1 <= pk;
        o_fund <= fd;
        @(posedge i_sys_clk);
        o_fault_det <= 1'b0;
    endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the transient earth stage
`timescale 1ns/10ps
`include "transient_stage_consts.svh"

module tb;
    localparam int TK = 10;
    logic        clk, rst_b, fdet, blk, wr, rd;
    logic [7:0]  addr, u0;
    logic [31:0] wdata, rdata, tstamp;
    logic [15:0] pk1, pk2, fund;
    logic [3:0]  grp_in;
    logic        start, trip, blocked, frc, grp, irq;
    int          errors, checks_done;

    fault_source_model u_src (
        .i_sys_clk(clk), .i_rst_b(rst_b), .o_fault_det(fdet), .o_peak1(pk1),
        .o_peak2(pk2), .o_fund(fund), .o_u0(u0), .o_time(tstamp)
    );

    transient_earth_stage #(.P_TICK_CYCLES(TK), .P_FORCE_MS(5)) u_dut (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_fault_det(fdet),
        .i_first_residual_peak_input(pk1), .i_second_residual_peak_input(pk2),
        .i_fund_peak(fund), .i_u0_level(u0), .i_time_stamp(tstamp), .i_block(blk),
        .i_grp_digital_pin(grp_in[0]), .i_grp_virtual_in(grp_in[1]),
        .i_grp_indicator(grp_in[2]), .i_grp_virtual_out(grp_in[3]),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_start(start), .o_trip(trip), .o_blocked(blocked), .o_force_flag(frc),
        .o_active_group(grp), .o_irq(irq)
    );

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, exp, rdata & m);
    endtask

    task automatic flt(input logic [15:0] pk, input logic [15:0] fd, input int gap);
        u_src.fire(pk, fd);
        tick(gap);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // whole run is about 7500 cycles
    initial begin
        #100000;
        errors++;
        finish_test();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        blk = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        grp_in = 4'h0;
        errors = 0;
        checks_done = 0;
        tick(4);
        rst_b <= 1'b1;
        rd_chk("grp1 reset", `REG_GRP1, '1, `GRP_RST);
        rd_chk("grp2 reset", `REG_GRP2, '1, `GRP_RST);
        rd_chk("unmapped", 8'h3c, '1, 32'h0);
        wr_reg(`REG_IRQ_EN, 32'hf);
        // steady sine: peak equal to fundamental, full count but no trip
        repeat (7) flt(16'h0100, 16'h0100, 250);
        rd_chk("sine status", `REG_STATUS, 32'hff03, 32'h0701);
        tick(450);
        // faults 25 ms apart with real transient peaks
        flt(16'h0200, 16'h0100, 250);
        rd_chk("restart count", `REG_STATUS, 32'hff00, 32'h0100);
        repeat (5) flt(16'h0200, 16'h0100, 250);
        #1 chk("trip early", 0, trip);
        flt(16'h0200, 16'h0100, 20);
        #1 chk("trip at op", 1, trip);
        rd_chk("trip status", `REG_STATUS, 32'h7fff03, 32'h640703);
        wr_reg(`REG_REC_SEL, 32'h0);
        rd_chk("record", `REG_REC_DATA, '1, 32'h64ff_0200);
        tick(450);
        #1 chk("trip released", 0, trip | start);
        rd_chk("count zero", `REG_STATUS, 32'hff03, 32'h0);
        rd_chk("irq status", `REG_IRQ_STAT, '1, 32'h3);
        #1 chk("irq up", 1, irq);
        wr_reg(`REG_IRQ_EN, 32'h0);
        #1 chk("irq masked", 0, irq);
        wr_reg(`REG_IRQ_CLR, 32'hf);
        rd_chk("irq cleared", `REG_IRQ_STAT, '1, 32'h0);
        wr_reg(`REG_IRQ_EN, 32'hf);
        // intermittent 100 ms: 60 ms gap keeps, 160 ms gap clears
        wr_reg(`REG_GRP1, 32'h0000_6407);
        flt(16'h0200, 16'h0100, 600);
        flt(16'h0200, 16'h0100, 5);
        rd_chk("count kept", `REG_STATUS, 32'hff00, 32'h0200);
        tick(1600);
        flt(16'h0200, 16'h0100, 5);
        rd_chk("count cleared", `REG_STATUS, 32'hff00, 32'h0100);
        tick(450);
        rd_chk("counts", `REG_COUNTS, '1, 32'h0001_0005);
        wr_reg(`REG_CTRL, 32'h300);
        rd_chk("counts cleared", `REG_COUNTS, '1, 32'h0);
        @(posedge clk) blk <= 1'b1;
        flt(16'h0200, 16'h0100, 5);
        #1 chk("blocked start", 0, start);
        chk("blocked flag", 1, blocked);
        rd_chk("block status", `REG_STATUS, 32'h7, 32'h4);
        @(posedge clk) blk <= 1'b0;
        rd_chk("block irq", `REG_IRQ_STAT, 32'h8, 32'h8);
        tick(450);
        // each group source in turn, then the manual choice
        for (int k = 0; k < 4; k++) begin
            wr_reg(`REG_CTRL, 32'(k + 1) << 4);
            @(posedge clk) grp_in <= 4'h1 << k;
            tick(5);
            #1 chk("group high", 1, grp);
            @(posedge clk) grp_in <= 4'h0;
            tick(5);
            #1 chk("group low", 0, grp);
        end
        wr_reg(`REG_CTRL, 32'h8);
        tick(2);
        #1 chk("manual group", 1, grp);
        wr_reg(`REG_CTRL, 32'h3);
        tick(2);
        #1 chk("force on", 1, frc);
        chk("forced start", 1, start);
        tick(70);
        #1 chk("force off", 0, frc);
        rd_chk("force irq", `REG_IRQ_STAT, 32'h4, 32'h4);
        wr_reg(`REG_CTRL, 32'h0);
        finish_test();
    end
endmodule

// ### verification/transient_stage_monitor.sv
// concurrent checks on the ports of the transient earth stage
`timescale 1ns/10ps

module transient_stage_monitor #(
    parameter int P_TICK_CYCLES = 10,
    parameter int P_FORCE_MS    = 5
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    // watched inputs
    input  wire logic        i_fault_det,
    input  wire logic [7:0]  i_u0_level,
    input  wire logic        i_block,
    input  wire logic        i_rd,
    // watched outputs
    input  wire logic [31:0] o_rdata,
    input  wire logic        o_start,
    input  wire logic        o_trip,
    input  wire logic        o_blocked,
    input  wire logic        o_force_flag,
    input  wire logic        o_irq
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // release is tick based, so the bounds keep a few ticks of slack
    localparam int GAP_LO  = 38 * P_TICK_CYCLES;
    localparam int GAP_HI  = 44 * P_TICK_CYCLES;
    localparam int FRC_MAX = (P_FORCE_MS + 2) * P_TICK_CYCLES;
    logic [31:0] gap_q;
    logic [31:0] frc_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_q <= 32'h0;
            frc_q <= 32'h0;
        end else begin
            gap_q <= i_fault_det ? 32'h0 : gap_q + ((gap_q != 32'hffff_ffff) ? 32'h1 : 32'h0);
            frc_q <= o_force_flag ? frc_q + 32'h1 : 32'h0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    chk_fault_start: assert property (i_fault_det && !i_block && i_u0_level == 8'hff
        |=> o_start)
        else $error("start missing after fault");
    chk_block_quiet: assert property (i_block |=> !o_start && !o_trip)
        else $error("start or trip while blocked");
    chk_blocked_copy: assert property (1'b1 |=> o_blocked == $past(i_block))
        else $error("blocked flag not one cycle behind block input");
    chk_start_holds: assert property (o_start && !o_force_flag && !i_block
        && gap_q < GAP_LO |=> o_start)
        else $error("start dropped before release time");
    chk_release_bound: assert property (gap_q == GAP_HI |-> !o_start || o_force_flag)
        else $error("start still up long after release time");
    chk_trip_rise: assert property ($rose(o_trip) && !o_force_flag |-> $past(o_start))
        else $error("trip rose without a preceding start");
    chk_trip_start: assert property (o_trip && !o_force_flag |-> o_start)
        else $error("trip held after release");
    chk_force_bound: assert property (frc_q < FRC_MAX)
        else $error("force flag outlived its timeout");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside the read answer cycle");

    cover property ($rose(o_trip));
    cover property ($fell(o_force_flag));
    cover property ($rose(o_blocked));
    cover property (o_irq && i_rd);
endmodule

bind transient_earth_stage transient_stage_monitor #(
    .P_TICK_CYCLES(P_TICK_CYCLES),
    .P_FORCE_MS   (P_FORCE_MS)
) u_mon (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_fault_det(i_fault_det),
    .i_u0_level(i_u0_level), .i_block(i_block), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked),
    .o_force_flag(o_force_flag), .o_irq(o_irq)
);
